//--- design/asr_pkg.sv
// constants, types and register map of the asynchronous serial receive block
package asr_pkg;

  typedef logic [7:0] asr_addr_t;
  typedef logic [31:0] asr_word_t;
  typedef logic [7:0] asr_byte_t;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam asr_addr_t OFF_MODE = 8'h00;
  localparam asr_addr_t OFF_ERR = 8'h04;
  localparam asr_addr_t OFF_RXBUF = 8'h08;
  localparam asr_addr_t OFF_BAUD = 8'h0c;
  localparam asr_addr_t OFF_IRQ_ST = 8'h10;
  localparam asr_addr_t OFF_IRQ_MASK = 8'h14;

  // ------------------------------------------------------------
  // serial_mode_register fields
  // ------------------------------------------------------------
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PSH = 4;
  localparam int MODE_PSL = 3;
  localparam int MODE_CHLEN8 = 2;
  localparam int MODE_STOP2 = 1;
  localparam int MODE_FIXED = 0;
  localparam asr_byte_t MODE_RST = 8'h01;

  // ------------------------------------------------------------
  // rx_error_status_register fields
  // ------------------------------------------------------------
  localparam int ERR_W = 3;
  localparam int ERR_PARITY = 2;
  localparam int ERR_FRAME = 1;
  localparam int ERR_OVERRUN = 0;

  // ------------------------------------------------------------
  // baud_control_register fields
  // ------------------------------------------------------------
  localparam int DIV_W = 5;
  localparam int DIV_LSB = 0;
  localparam int PRE_W = 2;
  localparam int PRE_LSB = 5;
  localparam int PRE_CNT_W = 3;
  localparam asr_byte_t BAUD_RST = 8'h1f;
  localparam asr_byte_t BAUD_MASK = 8'h7f;

  // ------------------------------------------------------------
  // interrupt status and mask fields
  // ------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_RXDONE = 0;
  localparam int IRQ_RXERR = 1;

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] LAST_BIT8 = 3'h7;
  localparam logic [CNT_W-1:0] LAST_BIT7 = 3'h6;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD = 2'b10,
    PAR_EVEN = 2'b11
  } asr_parity_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP = 3'b100
  } asr_rx_state_e;

endpackage

//--- design/asr_rx_if.sv
// link between the control logic and the receive shifter
interface asr_rx_if;
  import asr_pkg::*;
  logic bit_tick;
  logic restart;
  logic rx_en;
  logic char_len8;
  logic rxd;
  asr_parity_e parity_mode;
  logic done;
  asr_byte_t data;
  logic parity_err;
  logic frame_err;

  modport ctl (
    output rx_en, char_len8, rxd, parity_mode,
    input bit_tick, restart, done, data, parity_err, frame_err
  );
  modport rx (
    input bit_tick, rx_en, char_len8, rxd, parity_mode,
    output restart, done, data, parity_err, frame_err
  );
endinterface

//--- design/asr_baud_gen.sv
// baud generator: prescaler, 5-bit divider counter and halving stage
module asr_baud_gen
  import asr_pkg::*;
(
  input logic clk,
  input logic arst_n,
  input logic run,
  input logic restart,
  input logic [asr_pkg::PRE_W-1:0] prescale,
  input logic [asr_pkg::DIV_W-1:0] divisor,
  output logic bit_tick
);

  logic [PRE_CNT_W-1:0] pre_q;
  logic [DIV_W-1:0] div_q;
  logic phase_q;
  logic base_tick;
  logic wrap;
  logic half_tick;
  logic [DIV_W-1:0] div_inc;

  // base clock: clk divided by 1, 2, 4 or 8
  assign base_tick = (prescale == 2'h0) ? 1'b1 :
                     (prescale == 2'h1) ? pre_q[0] :
                     (prescale == 2'h2) ? &pre_q[1:0] : &pre_q;
  assign div_inc = DIV_W'(div_q + 5'h01);
  // divisor 0 wraps after 32 base clocks
  assign wrap = (div_inc == divisor);
  assign half_tick = base_tick & wrap;
  // halved output; restart lines the first tick up with mid start bit
  assign bit_tick = half_tick & phase_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= PRE_CNT_W'(pre_q + 3'h1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 5'h00;
      phase_q <= 1'b1;
    end else if (!run || restart) begin
      div_q <= 5'h00;
      phase_q <= 1'b1;
    end else if (base_tick) begin
      div_q <= wrap ? 5'h00 : div_inc;
      phase_q <= phase_q ^ wrap;
    end
  end

endmodule

//--- design/asr_rx.sv
// receive shifter: start detect, data, parity and stop sampling
module asr_rx
  import asr_pkg::*;
(
  input logic clk,
  input logic arst_n,
  asr_rx_if.rx bus
);

  asr_rx_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  asr_byte_t shift_q, shift_d;
  asr_byte_t data_q, data_d;
  logic par_q, par_d;
  logic perr_q, perr_d;
  logic ferr_q, ferr_d;
  logic done_q, done_d;
  logic restart;
  logic tick;
  logic par_fold;
  logic [CNT_W-1:0] last_bit;

  function automatic logic parity_bad(input asr_parity_e mode, input logic ones_odd);
    case (mode)
      PAR_ODD: parity_bad = !ones_odd;
      PAR_EVEN: parity_bad = ones_odd;
      default: parity_bad = 1'b0;
    endcase
  endfunction

  assign tick = bus.bit_tick;
  assign par_fold = par_q ^ bus.rxd;
  assign last_bit = bus.char_len8 ? LAST_BIT8 : LAST_BIT7;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    data_d = data_q;
    par_d = par_q;
    perr_d = perr_q;
    ferr_d = ferr_q;
    done_d = 1'b0;
    restart = 1'b0;
    case (state_q)
      RX_IDLE: begin
        if (bus.rx_en && !bus.rxd) begin
          state_d = RX_START;
          restart = 1'b1;
        end
      end
      RX_START: begin
        if (tick) begin
          if (bus.rxd) begin
            state_d = RX_IDLE;
          end else begin
            state_d = RX_DATA;
            cnt_d = 3'h0;
            par_d = 1'b0;
            perr_d = 1'b0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          shift_d = {bus.rxd, shift_q[DATA_W-1:1]};
          par_d = par_fold;
          if (cnt_q == last_bit) begin
            state_d = (bus.parity_mode == PAR_NONE) ? RX_STOP : RX_PARITY;
          end else begin
            cnt_d = CNT_W'(cnt_q + 3'h1);
          end
        end
      end
      RX_PARITY: begin
        if (tick) begin
          perr_d = parity_bad(bus.parity_mode, par_fold);
          state_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick) begin
          // a second stop bit is never looked at
          ferr_d = !bus.rxd;
          done_d = 1'b1;
          data_d = bus.char_len8 ? shift_q : {1'b0, shift_q[DATA_W-1:1]};
          state_d = RX_IDLE;
        end
      end
      default: begin
        state_d = RX_IDLE;
      end
    endcase
    if (!bus.rx_en) begin
      state_d = RX_IDLE;
      done_d = 1'b0;
      restart = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= RX_IDLE;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      data_q <= 8'h00;
      par_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      data_q <= data_d;
      par_q <= par_d;
      perr_q <= perr_d;
      ferr_q <= ferr_d;
      done_q <= done_d;
    end
  end

  assign bus.restart = restart;
  assign bus.done = done_q;
  assign bus.data = data_q;
  assign bus.parity_err = perr_q;
  assign bus.frame_err = ferr_q;

endmodule

//--- design/asr_top.sv
// serial receive control top: apb registers, error flags, overrun, interrupt
module asr_top
  import asr_pkg::*;
(
  input logic clk,
  input logic arst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input asr_pkg::asr_addr_t paddr,
  input asr_pkg::asr_word_t pwdata,
  output asr_pkg::asr_word_t prdata,
  output logic pready,
  output logic pslverr,
  input logic rxd,
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  asr_byte_t mode_q, mode_d;
  asr_byte_t baud_q, baud_d;
  logic [ERR_W-1:0] err_q, err_d;
  asr_byte_t rxbuf_q, rxbuf_d;
  logic full_q, full_d;
  logic [IRQ_W-1:0] irq_st_q, irq_st_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic wait_q;
  asr_word_t prdata_q, prdata_d;
  logic rxd_meta_q, rxd_sync_q;

  asr_rx_if rxb();

  function automatic logic addr_ok(input asr_addr_t a);
    addr_ok = (a == OFF_MODE) || (a == OFF_ERR) || (a == OFF_RXBUF) ||
              (a == OFF_BAUD) || (a == OFF_IRQ_ST) || (a == OFF_IRQ_MASK);
  endfunction

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic setup;
  logic access;
  logic xfer;
  logic wr;
  logic rd;
  logic err_rd_access;
  asr_word_t rd_mux;

  assign setup = psel && !penable;
  assign access = psel && penable;
  // first access cycle of an error status read is held off
  assign err_rd_access = access && !pwrite && (paddr == OFF_ERR);
  assign pready = !(err_rd_access && !wait_q);
  assign pslverr = access && !addr_ok(paddr);
  assign xfer = access && pready;
  assign wr = xfer && pwrite && addr_ok(paddr);
  assign rd = xfer && !pwrite && addr_ok(paddr);

  assign rd_mux = !addr_ok(paddr) ? 32'h0000_0000 :
                  (paddr == OFF_MODE) ? {24'h00_0000, mode_q} :
                  (paddr == OFF_ERR) ? {29'h0000_0000, err_q} :
                  (paddr == OFF_RXBUF) ? {24'h00_0000, rxbuf_q} :
                  (paddr == OFF_BAUD) ? {24'h00_0000, baud_q} :
                  (paddr == OFF_IRQ_ST) ? {30'h0000_0000, irq_st_q} :
                  {30'h0000_0000, irq_mask_q};
  // read data captured in the setup cycle, held through any wait
  assign prdata_d = setup ? rd_mux : prdata_q;
  assign prdata = prdata_q;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  logic wr_mode;
  logic wr_baud;
  logic wr_irq_st;
  logic wr_irq_mask;

  assign wr_mode = wr && (paddr == OFF_MODE);
  assign wr_baud = wr && (paddr == OFF_BAUD);
  assign wr_irq_st = wr && (paddr == OFF_IRQ_ST);
  assign wr_irq_mask = wr && (paddr == OFF_IRQ_MASK);

  // bit 0 of the mode register always reads one
  assign mode_d = wr_mode ? (pwdata[7:0] | MODE_RST) : mode_q;
  assign baud_d = wr_baud ? (pwdata[7:0] & BAUD_MASK) : baud_q;
  assign irq_mask_d = wr_irq_mask ? pwdata[IRQ_W-1:0] : irq_mask_q;

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  logic power;
  logic rx_run;
  logic buf_rd;
  logic err_rd;
  logic frame_done;
  logic overrun;
  logic store;
  logic [ERR_W-1:0] err_set;
  logic [ERR_W-1:0] err_clr;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;

  assign power = mode_q[MODE_POWER];
  assign rx_run = power && mode_q[MODE_RXE];

  assign rxb.rx_en = rx_run;
  assign rxb.char_len8 = mode_q[MODE_CHLEN8];
  assign rxb.parity_mode = asr_parity_e'({mode_q[MODE_PSH], mode_q[MODE_PSL]});
  assign rxb.rxd = rxd_sync_q;

  assign buf_rd = rd && (paddr == OFF_RXBUF);
  assign err_rd = rd && (paddr == OFF_ERR);
  assign frame_done = rxb.done;
  // buffer still unread when the next frame completes
  assign overrun = frame_done && full_q && !buf_rd;
  assign store = frame_done && !overrun;

  assign err_set[ERR_OVERRUN] = overrun;
  assign err_set[ERR_FRAME] = frame_done && rxb.frame_err;
  assign err_set[ERR_PARITY] = frame_done && rxb.parity_err;
  // a read clears only the flags it reported; a new event wins
  assign err_clr = err_rd ? prdata_q[ERR_W-1:0] : 3'h0;
  assign err_d = power ? ((err_q & ~err_clr) | err_set) : 3'h0;

  // discarded character leaves the buffer as it was
  assign rxbuf_d = store ? rxb.data : rxbuf_q;
  assign full_d = power && (store || (full_q && !buf_rd));

  assign irq_ev[IRQ_RXDONE] = store;
  assign irq_ev[IRQ_RXERR] = |err_set;
  assign irq_clr = wr_irq_st ? pwdata[IRQ_W-1:0] : 2'h0;
  assign irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;
  assign irq = |(irq_st_q & irq_mask_q);

  asr_baud_gen u_baud (
    .clk(clk),
    .arst_n(arst_n),
    .run(rx_run),
    .restart(rxb.restart),
    .prescale(baud_q[PRE_LSB +: PRE_W]),
    .divisor(baud_q[DIV_LSB +: DIV_W]),
    .bit_tick(rxb.bit_tick)
  );

  asr_rx u_rx (
    .clk(clk),
    .arst_n(arst_n),
    .bus(rxb)
  );

  // ------------------------------------------------------------
  // flip-flops
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
    end else begin
      rxd_meta_q <= rxd;
      rxd_sync_q <= rxd_meta_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= err_rd_access && !wait_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_RST;
      baud_q <= BAUD_RST;
      irq_mask_q <= 2'h0;
      prdata_q <= 32'h0000_0000;
    end else begin
      mode_q <= mode_d;
      baud_q <= baud_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_q <= 3'h0;
      rxbuf_q <= 8'h00;
      full_q <= 1'b0;
      irq_st_q <= 2'h0;
    end else begin
      err_q <= err_d;
      rxbuf_q <= rxbuf_d;
      full_q <= full_d;
      irq_st_q <= irq_st_d;
    end
  end

endmodule

//--- testbench/asr_chk.sv
// bus timing and error checks on the ports of the serial receive top
module asr_chk
  import asr_pkg::*;
(
  input logic clk,
  input logic arst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input asr_pkg::asr_addr_t paddr,
  input asr_pkg::asr_word_t pwdata,
  input asr_pkg::asr_word_t prdata,
  input logic pready,
  input logic pslverr,
  input logic rxd,
  input logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mapped;
  logic acc;
  assign mapped = paddr inside {OFF_MODE, OFF_ERR, OFF_RXBUF, OFF_BAUD, OFF_IRQ_ST, OFF_IRQ_MASK};
  assign acc = psel && penable;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence seq_err_setup;
    psel && !penable && !pwrite && paddr == OFF_ERR;
  endsequence
  sequence seq_one_wait;
    acc && !pready ##1 acc && pready;
  endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  chk_err_wait_one: assert property (seq_err_setup |=> seq_one_wait)
    else $error("status read without exactly one wait");
  chk_ready_no_wait: assert property (acc && !(paddr == OFF_ERR && !pwrite) |-> pready)
    else $error("wait inserted on a plain access");
  chk_slverr_map: assert property (acc |-> pslverr == !mapped)
    else $error("slave error does not match address map");
  chk_unmapped_zero: assert property (acc && !mapped && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  chk_rdata_hold: assert property (acc && !pready |=> $stable(prdata))
    else $error("read data moved during wait");
  chk_irq_reset: assert property ($rose(arst_n) |-> !irq)
    else $error("interrupt high out of reset");
  cov_err_read: cover property (seq_err_setup ##1 seq_one_wait);
endmodule

bind asr_top asr_chk u_chk (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .irq(irq));

//--- testbench/asr_partner.sv
// remote serial transmitter model driving the receive pin
module asr_partner #(
  parameter int BIT_CLK = 8
) (
  input wire logic clk,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  // start, lsb-first data, optional parity, one stop; called right after a clock edge
  task automatic send(input logic [7:0] d, input logic par_en, input logic par_bit,
                      input logic stop_bit);
    logic [10:0] bits;
    int n;
    bits = {stop_bit, par_bit, d, 1'b0};
    n = par_en ? 11 : 10;
    if (!par_en) bits[9] = stop_bit;
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT_CLK) @(posedge clk);
    end
    if (!stop_bit) begin
      rxd <= 1'b1;
      repeat (BIT_CLK) @(posedge clk);
    end
  endtask
endmodule

//--- testbench/tb_async_serial_receive_control.sv
// self-checking bench for the serial receive control block
module tb_async_serial_receive_control;
  import asr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, rxd, irq;
  asr_addr_t paddr;
  asr_word_t pwdata, prdata;
  asr_word_t exp_q[$];
  int mismatches = 0;
  int tests_run = 0;
  int seed = 32'h88ec46db;
  asr_byte_t d, d2;
  asr_parity_e pm;
  logic pb;

  asr_top u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .irq(irq));
  asr_partner #(.BIT_CLK(8)) u_prt (.clk(clk), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // the interrupt level is looked at one edge after the write that moved it
  task automatic irq_is(input logic e);
    @(posedge clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask

  task automatic cmp(input asr_word_t got, input asr_word_t exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------
  // apb master
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input asr_addr_t a, input asr_word_t wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n >= 20) cmp(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input asr_addr_t a, input asr_word_t wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rd(input asr_addr_t a, input asr_word_t e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // read results are compared against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) cmp(prdata, exp_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFF_MODE, 32'h01);
    rd(OFF_BAUD, 32'h1f);
    rd(OFF_ERR, 32'h0);
    rd(OFF_RXBUF, 32'h0);
    rd(OFF_IRQ_ST, 32'h0);
    rd(OFF_IRQ_MASK, 32'h0);
    wr(8'h20, 32'hff);
    rd(8'h20, 32'h0);
    wr(OFF_BAUD, 32'hff);
    rd(OFF_BAUD, 32'h7f);
    wr(OFF_BAUD, 32'h04);
    // parity modes, each but none with a wrong parity bit
    for (int m = 0; m < 4; m++) begin
      pm = asr_parity_e'(m);
      wr(OFF_MODE, 32'h81);
      repeat (4) @(posedge clk);
      wr(OFF_MODE, 32'ha5 | (m << 3));
      d = 8'($random(seed));
      pb = (pm == PAR_EVEN) ? ~(^d) : (pm == PAR_ODD) ? (^d) : 1'b1;
      u_prt.send(d, pm != PAR_NONE, pb, 1'b1);
      rd(OFF_ERR, {29'h0, (pm == PAR_ODD || pm == PAR_EVEN), 2'b00});
      rd(OFF_RXBUF, {24'h0, d});
    end
    // framing with two stop bits configured
    wr(OFF_MODE, 32'h81);
    repeat (4) @(posedge clk);
    wr(OFF_MODE, 32'ha7);
    d = 8'($random(seed));
    u_prt.send(d, 1'b0, 1'b0, 1'b0);
    rd(OFF_ERR, 32'h2);
    rd(OFF_RXBUF, {24'h0, d});
    d = 8'($random(seed));
    d2 = ~d;
    u_prt.send(d, 1'b0, 1'b0, 1'b1);
    u_prt.send(d2, 1'b0, 1'b0, 1'b1);
    rd(OFF_ERR, 32'h1);
    rd(OFF_RXBUF, {24'h0, d});
    wr(OFF_RXBUF, 32'hff);
    rd(OFF_RXBUF, {24'h0, d});
    d2 = 8'($random(seed));
    u_prt.send(d2, 1'b0, 1'b0, 1'b1);
    rd(OFF_ERR, 32'h0);
    rd(OFF_RXBUF, {24'h0, d2});
    // seven data bits, base clock halved; data bit 7 high stands where the stop bit is sampled
    wr(OFF_MODE, 32'h81);
    wr(OFF_BAUD, 32'h22);
    repeat (4) @(posedge clk);
    wr(OFF_MODE, 32'ha1);
    d = 8'($random(seed)) | 8'h80;
    u_prt.send(d, 1'b0, 1'b0, 1'b1);
    rd(OFF_ERR, 32'h0);
    rd(OFF_RXBUF, {24'h0, 1'b0, d[6:0]});
    // interrupt mask and clear
    rd(OFF_IRQ_ST, 32'h3);
    irq_is(1'b0);
    wr(OFF_IRQ_MASK, 32'h1);
    irq_is(1'b1);
    wr(OFF_IRQ_ST, 32'h1);
    irq_is(1'b0);
    wr(OFF_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    wr(OFF_IRQ_ST, 32'h2);
    irq_is(1'b0);
    rd(OFF_IRQ_ST, 32'h0);
    wr(OFF_MODE, 32'h81);
    wr(OFF_MODE, 32'h01);
    rd(OFF_MODE, 32'h01);
    conclude();
  end
endmodule
